// ==== rfnd_pkg.sv ====
// shared constants for the rf feedback divider programming link
package rfnd_pkg;

  // serial word layout
  localparam int WORD_BITS = 24;
  localparam int CNT_BITS  = 5;
  localparam int ADDR_MSB  = 3;
  localparam int ADDR_LSB  = 0;
  localparam int N_SEL_BIT = 0;
  localparam logic [3:0] ADDR_R1 = 4'h3;
  localparam logic       N_SEL_VAL = 1'h0;

  // divide word register fields
  localparam int N_MSB   = 23;
  localparam int N_LSB   = 13;
  localparam int NUM_MSB = 12;
  localparam int NUM_LSB = 1;

  // reference / prescaler / denominator register fields
  localparam int PD_BIT   = 23;
  localparam int PSEL_BIT = 22;
  localparam int RDIV_MSB = 21;
  localparam int RDIV_LSB = 16;
  localparam int DEN_MSB  = 15;
  localparam int DEN_LSB  = 4;

  // split of the 11-bit divide word
  localparam int C_MSB = 10;
  localparam int C_LSB = 4;
  localparam int B_MSB = 3;
  localparam int B_LSB = 2;
  localparam int A_MSB = 1;
  localparam int A_LSB = 0;

  // prescaler base moduli
  localparam logic       PSEL_SMALL = 1'h0;
  localparam logic [4:0] BASE_SMALL = 5'h08;
  localparam logic [4:0] BASE_LARGE = 5'h10;

  // legal divide word ranges
  localparam logic [10:0] SM_MIN      = 11'h019;
  localparam logic [10:0] SM_ORD2_MAX = 11'h01A;
  localparam logic [10:0] SM_ORD3_MAX = 11'h01E;
  localparam logic [10:0] SM_MAX      = 11'h3FF;
  localparam logic [10:0] LG_MIN      = 11'h031;
  localparam logic [10:0] LG_ORD2_LO  = 11'h032;
  localparam logic [10:0] LG_ORD3_LO  = 11'h036;
  localparam logic [10:0] LG_ORD3_HI  = 11'h7F8;
  localparam logic [10:0] LG_ORD2_HI  = 11'h7FC;
  localparam logic [10:0] LG_MAX      = 11'h7FD;

  // modulator orders
  localparam logic [2:0] ORD_SECOND = 3'h2;
  localparam logic [2:0] ORD_THIRD  = 3'h3;
  localparam logic [2:0] ORD_RESET  = 3'h3;

  // controller register map (byte offsets)
  localparam logic [3:0] OFS_DIVIDE = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h4;
  localparam logic [3:0] OFS_ORDER  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int DV_N_MSB   = 10;
  localparam int DV_N_LSB   = 0;
  localparam int DV_NUM_MSB = 27;
  localparam int DV_NUM_LSB = 16;
  localparam int ORD_MSB    = 2;
  localparam int STS_BUSY   = 0;
  localparam int STS_REFUSE = 1;

  // serial timing
  localparam int SCK_HALF_DEF = 2;

endpackage

// ==== rfnd_link_if.sv ====
// three-wire programming link between controller and divider
`timescale 1ns/1ps
`default_nettype none
interface rfnd_link_if;
  logic ser_clk;
  logic ser_data;
  logic latch_strobe;

  modport host
  (
    output ser_clk,
    output ser_data,
    output latch_strobe
  );

  modport device
  (
    input ser_clk,
    input ser_data,
    input latch_strobe
  );
endinterface
`default_nettype wire

// ==== rfnd_device.sv ====
// divider end: serial word capture, divide word and reference/prescaler latches
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - prescaler offers 8/9/12/13 or 16/17/20/21 sets
// - total divide is base*C plus 4B plus A
// - host checks range and order only, not C against max of A, B
// - small prescaler: spare swallow bit lent to the modulator
// - small prescaler: divide word 25 to 1023
// - small prescaler: 25-30 need low modulator order
// - large prescaler: divide word 49 to 2045
// - large prescaler: range ends need low order
// - code 0011 latch holds pd, psel, ref, denominator
// - 24-bit words, msb first, latched on strobe
// - divide word selected by one zero bit
// - select 0 small set, 1 large set
// - divide write restarts lock detect counters
module rfnd_device
  import rfnd_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // programming link
  rfnd_link_if.device      link,
  // modulator side
  input  wire logic        MOD_SPARE_BIT,
  // divide word
  output logic [10:0]      N_WORD,
  output logic [11:0]      NUM_LOW,
  output logic [6:0]       MAIN_COUNT,
  output logic [1:0]       PLUS_FOUR,
  output logic [1:0]       PLUS_ONE,
  // prescaler and divide result
  output logic             PRESCALER_SEL,
  output logic [4:0]       PRESCALER_BASE,
  output logic             SPARE_BIT_FREE,
  output logic [11:0]      DIVIDE_TOTAL,
  // reference and power
  output logic             POWERDOWN,
  output logic [5:0]       REF_DIV,
  output logic [11:0]      DEN_LOW,
  // lock detect restart
  output logic             LOCK_REINIT
);

  ////////////////////////////////////////////////////////////////////////////
  // total divide from the base modulus and the swallow counts

  function automatic logic [11:0] divide_total
  (
    input logic       psel,
    input logic [6:0] c,
    input logic [1:0] b,
    input logic [1:0] a
  );
    logic [11:0] base;
    logic [23:0] prod;
    base = psel ? {7'h00, BASE_LARGE} : {7'h00, BASE_SMALL};
    prod = base * {5'h00, c};
    divide_total = prod[11:0] + {8'h00, b, 2'h0} + {10'h000, a};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] shift_next;
  logic                 sclk_prev_reg;
  logic                 le_prev_reg;
  logic [10:0]          n_word_reg;
  logic [11:0]          num_low_reg;
  logic                 pd_reg;
  logic                 psel_reg;
  logic [5:0]           rdiv_reg;
  logic [11:0]          den_reg;
  logic                 reinit_reg;
  logic [11:0]          total_reg;
  logic [11:0]          total_next;

  ////////////////////////////////////////////////////////////////////////////
  // link decode

  logic       sclk_rise;
  logic       le_rise;
  logic       sel_n;
  logic       sel_r1;
  logic       load_n;
  logic       load_r1;
  logic [6:0] c_cnt;
  logic [1:0] b_cnt;
  logic [1:0] a_cnt;
  logic [1:0] b_eff;
  logic       spare_free;

  assign sclk_rise = link.ser_clk & ~sclk_prev_reg;
  assign le_rise   = link.latch_strobe & ~le_prev_reg;

  assign shift_next = {shift_reg[WORD_BITS-2:0], link.ser_data};

  assign sel_n  = (shift_reg[N_SEL_BIT] == N_SEL_VAL);
  assign sel_r1 = (shift_reg[ADDR_MSB:ADDR_LSB] == ADDR_R1);

  assign load_n  = le_rise & sel_n;
  assign load_r1 = le_rise & sel_r1;

  assign c_cnt = n_word_reg[C_MSB:C_LSB];
  assign b_cnt = n_word_reg[B_MSB:B_LSB];
  assign a_cnt = n_word_reg[A_MSB:A_LSB];

  assign spare_free = (psel_reg == PSEL_SMALL);
  assign b_eff      = spare_free ? {MOD_SPARE_BIT, b_cnt[0]} : b_cnt;

  assign total_next = divide_total(psel_reg, c_cnt, b_eff, a_cnt);

  ////////////////////////////////////////////////////////////////////////////
  // edge history and shift register

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sclk_prev_reg <= 1'h0;
      le_prev_reg   <= 1'h0;
      shift_reg     <= 24'h000000;
    end
    else
    begin
      sclk_prev_reg <= link.ser_clk;
      le_prev_reg   <= link.latch_strobe;
      if (sclk_rise)
      begin
        shift_reg <= shift_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide word latch

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      n_word_reg  <= 11'h000;
      num_low_reg <= 12'h000;
    end
    else if (load_n)
    begin
      n_word_reg  <= shift_reg[N_MSB:N_LSB];
      num_low_reg <= shift_reg[NUM_MSB:NUM_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference, prescaler and denominator latch

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pd_reg   <= 1'h0;
      psel_reg <= 1'h0;
      rdiv_reg <= 6'h00;
      den_reg  <= 12'h000;
    end
    else if (load_r1)
    begin
      pd_reg   <= shift_reg[PD_BIT];
      psel_reg <= shift_reg[PSEL_BIT];
      rdiv_reg <= shift_reg[RDIV_MSB:RDIV_LSB];
      den_reg  <= shift_reg[DEN_MSB:DEN_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock detect restart and registered divide result

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      reinit_reg <= 1'h0;
      total_reg  <= 12'h000;
    end
    else
    begin
      reinit_reg <= load_n;
      total_reg  <= total_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign N_WORD     = n_word_reg;
  assign NUM_LOW    = num_low_reg;
  assign MAIN_COUNT = c_cnt;
  assign PLUS_FOUR  = b_cnt;
  assign PLUS_ONE   = a_cnt;

  assign PRESCALER_SEL  = psel_reg;
  assign PRESCALER_BASE = spare_free ? BASE_SMALL : BASE_LARGE;
  assign SPARE_BIT_FREE = spare_free;
  assign DIVIDE_TOTAL   = total_reg;

  assign POWERDOWN   = pd_reg;
  assign REF_DIV     = rdiv_reg;
  assign DEN_LOW     = den_reg;
  assign LOCK_REINIT = reinit_reg;

endmodule
`default_nettype wire

// ==== rfnd_host.sv ====
// controller end: register slave, range checks and serial word sender
`timescale 1ns/1ps
`default_nettype none
module rfnd_host
  import rfnd_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DEF
)
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // register bus
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // programming link
  rfnd_link_if.host        link
);

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_LOW   = 3'h1,
    ST_HIGH  = 3'h2,
    ST_LATCH = 3'h3,
    ST_GAP   = 3'h4
  } rfnd_hstate_t;

  ////////////////////////////////////////////////////////////////////////////
  // legality of a divide word for prescaler and modulator order

  function automatic logic n_legal
  (
    input logic        psel,
    input logic [2:0]  ord,
    input logic [10:0] n
  );
    logic low_ord;
    low_ord = (ord == ORD_SECOND) || (ord == ORD_THIRD);
    if (psel == PSEL_SMALL)
    begin
      if ((n < SM_MIN) || (n > SM_MAX))
        n_legal = 1'h0;
      else if (n <= SM_ORD2_MAX)
        n_legal = (ord == ORD_SECOND);
      else if (n <= SM_ORD3_MAX)
        n_legal = low_ord;
      else
        n_legal = 1'h1;
    end
    else
    begin
      if ((n < LG_MIN) || (n > LG_MAX))
        n_legal = 1'h0;
      else if ((n <= LG_ORD2_LO) || (n >= LG_ORD2_HI))
        n_legal = (ord == ORD_SECOND);
      else if ((n <= LG_ORD3_LO) || (n >= LG_ORD3_HI))
        n_legal = low_ord;
      else
        n_legal = 1'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  rfnd_hstate_t         state_reg;
  rfnd_hstate_t         state_next;
  logic [10:0]          n_reg;
  logic [11:0]          num_reg;
  logic [23:0]          cfg_reg;
  logic [2:0]           ord_reg;
  logic                 refuse_reg;
  logic                 rd_ack_reg;
  logic [31:0]          rdata_reg;
  logic [WORD_BITS-1:0] sh_reg;
  logic [CNT_BITS-1:0]  bit_reg;
  logic [7:0]           div_reg;
  logic                 sck_reg;
  logic                 le_reg;
  logic                 dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        busy;
  logic        wr_div;
  logic        wr_cfg;
  logic        stall;
  logic        wr_ok;
  logic        div_ok;
  logic        launch;
  logic        tick;
  logic        last_bit;
  logic [31:0] rd_mux;
  logic [10:0] wr_n;

  assign busy   = (state_reg != ST_IDLE);
  assign wr_div = AVS_WRITE && (AVS_ADDRESS == OFS_DIVIDE);
  assign wr_cfg = AVS_WRITE && (AVS_ADDRESS == OFS_CONFIG);
  assign stall  = (wr_div || wr_cfg) && busy;
  assign wr_ok  = AVS_WRITE && !stall;
  assign wr_n   = AVS_WRITEDATA[DV_N_MSB:DV_N_LSB];
  assign div_ok = n_legal(cfg_reg[PSEL_BIT], ord_reg, wr_n);
  assign launch = wr_ok && (wr_cfg || (wr_div && div_ok));

  assign AVS_WAITREQUEST = stall || (AVS_READ && !rd_ack_reg);
  assign AVS_READDATA    = rdata_reg;

  assign rd_mux = (AVS_ADDRESS == OFS_DIVIDE) ? {4'h0, num_reg, 5'h00, n_reg} :
                  (AVS_ADDRESS == OFS_CONFIG) ? {8'h00, cfg_reg} :
                  (AVS_ADDRESS == OFS_ORDER)  ? {29'h00000000, ord_reg} :
                  (AVS_ADDRESS == OFS_STATUS) ? {30'h00000000, refuse_reg, busy} :
                  32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // register slave

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      n_reg      <= 11'h000;
      num_reg    <= 12'h000;
      cfg_reg    <= 24'h000000;
      ord_reg    <= ORD_RESET;
      refuse_reg <= 1'h0;
      rd_ack_reg <= 1'h0;
      rdata_reg  <= 32'h00000000;
    end
    else
    begin
      rd_ack_reg <= AVS_READ && !rd_ack_reg;
      if (AVS_READ && !rd_ack_reg)
        rdata_reg <= rd_mux;
      if (wr_ok && wr_div && div_ok)
      begin
        n_reg   <= wr_n;
        num_reg <= AVS_WRITEDATA[DV_NUM_MSB:DV_NUM_LSB];
      end
      if (wr_ok && wr_cfg)
        cfg_reg <= {AVS_WRITEDATA[PD_BIT:DEN_LSB], ADDR_R1};
      if (wr_ok && (AVS_ADDRESS == OFS_ORDER))
        ord_reg <= AVS_WRITEDATA[ORD_MSB:0];
      // refusal sets over a software clear
      if (wr_ok && wr_div && !div_ok)
        refuse_reg <= 1'h1;
      else if (wr_ok && (AVS_ADDRESS == OFS_STATUS) && AVS_WRITEDATA[STS_REFUSE])
        refuse_reg <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial sender

  assign tick     = (div_reg == 8'(SCK_HALF - 1));
  assign last_bit = (bit_reg == CNT_BITS'(WORD_BITS - 1));

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (launch) state_next = ST_LOW;
      ST_LOW:   if (tick) state_next = ST_HIGH;
      ST_HIGH:  if (tick) state_next = last_bit ? ST_LATCH : ST_LOW;
      ST_LATCH: if (tick) state_next = ST_GAP;
      ST_GAP:   if (tick) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= ST_IDLE;
      sh_reg    <= 24'h000000;
      bit_reg   <= 5'h00;
      div_reg   <= 8'h00;
      sck_reg   <= 1'h0;
      le_reg    <= 1'h0;
      dat_reg   <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      div_reg   <= (state_reg == ST_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
      if (launch)
      begin
        sh_reg  <= wr_div ? {wr_n, AVS_WRITEDATA[DV_NUM_MSB:DV_NUM_LSB], N_SEL_VAL} :
                            {AVS_WRITEDATA[PD_BIT:DEN_LSB], ADDR_R1};
        bit_reg <= 5'h00;
      end
      else if ((state_reg == ST_HIGH) && tick)
      begin
        sh_reg  <= {sh_reg[WORD_BITS-2:0], 1'h0};
        bit_reg <= bit_reg + 5'h01;
      end
      sck_reg <= (state_next == ST_HIGH);
      le_reg  <= (state_next == ST_LATCH);
      dat_reg <= launch ? (wr_div ? wr_n[DV_N_MSB] : AVS_WRITEDATA[PD_BIT]) :
                 ((state_reg == ST_HIGH) && tick) ? sh_reg[WORD_BITS-2] : dat_reg;
    end
  end

  assign link.ser_clk      = sck_reg;
  assign link.latch_strobe = le_reg;
  assign link.ser_data     = dat_reg;

endmodule
`default_nettype wire

// ==== rfnd_link_asserts.sv ====
// protocol checks on the three-wire programming link
`timescale 1ns/1ps
`default_nettype none
module rfnd_link_asserts
#(
  parameter int SCK_HALF = 2
)
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // link
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe
);
  logic [7:0] hi_len;
  logic [7:0] lo_len;
  logic [7:0] stb_len;
  logic [7:0] bit_cnt;
  logic       clk_d;
  wire  logic clk_rise = ser_clk & ~clk_d;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      hi_len  <= 8'h00;
      lo_len  <= 8'h00;
      stb_len <= 8'h00;
      bit_cnt <= 8'h00;
      clk_d   <= 1'b0;
    end
    else
    begin
      hi_len  <= ser_clk ? hi_len + 8'h01 : 8'h00;
      lo_len  <= (ser_clk || lo_len == 8'hFF) ? (ser_clk ? 8'h00 : lo_len) : lo_len + 8'h01;
      stb_len <= latch_strobe ? stb_len + 8'h01 : 8'h00;
      bit_cnt <= latch_strobe ? 8'h00 : bit_cnt + 8'(clk_rise);
      clk_d   <= ser_clk;
    end
  end

  property p_clk_high_len;
    $fell(ser_clk) |-> hi_len == 8'(SCK_HALF);
  endproperty
  a_clk_high_len: assert property (p_clk_high_len) else $error("serial clock high phase wrong length");
  property p_clk_low_len;
    $rose(ser_clk) |-> lo_len >= 8'(SCK_HALF);
  endproperty
  a_clk_low_len: assert property (p_clk_low_len) else $error("serial clock low phase too short");
  property p_data_stable;
    ser_clk && $past(ser_clk) |-> $stable(ser_data);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while clock high");
  property p_word_len;
    $rose(latch_strobe) |-> bit_cnt == 8'd24;
  endproperty
  a_word_len: assert property (p_word_len) else $error("strobe without 24 clocked bits");
  property p_bits_bounded;
    bit_cnt <= 8'd24;
  endproperty
  a_bits_bounded: assert property (p_bits_bounded) else $error("more than 24 bits in one word");
  property p_no_clk_in_strobe;
    latch_strobe |-> !ser_clk;
  endproperty
  a_no_clk_in_strobe: assert property (p_no_clk_in_strobe) else $error("clock high during strobe");
  property p_strobe_len;
    $fell(latch_strobe) |-> stb_len == 8'(SCK_HALF);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe pulse wrong length");
  property p_gap;
    $fell(latch_strobe) |-> !ser_clk ##1 !ser_clk;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after strobe");

  c_strobe: cover property ($rose(latch_strobe));
  c_full_word: cover property (bit_cnt == 8'd24);
  c_clk_fall: cover property ($fell(ser_clk));
endmodule
`default_nettype wire

// ==== rf_n_divider_config_bench.sv ====
// self-checking bench: controller and divider joined over the link
`timescale 1ns/1ps
`default_nettype none
module rf_n_divider_config_bench
  import rfnd_pkg::*;
;
  logic        MCLK;
  logic        RST_N;
  logic        spare;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] readdata;
  logic        waitreq;
  logic [10:0] n_word;
  logic [11:0] num_low;
  logic [6:0]  main_c;
  logic [1:0]  p4;
  logic [1:0]  p1;
  logic        psel_o;
  logic [4:0]  base;
  logic        free;
  logic [11:0] total;
  logic        pd_o;
  logic [5:0]  ref_o;
  logic [11:0] den_o;
  logic        reinit;
  logic        clk_d;
  logic        stb_d;
  logic [23:0] mon_sr;
  logic [23:0] exp_word;
  int          n_errors;
  int          checks;
  int          reinits;

  rfnd_link_if link();
  rfnd_device rfnd_device_inst (.MCLK(MCLK), .RST_N(RST_N), .link(link), .MOD_SPARE_BIT(spare),
    .N_WORD(n_word), .NUM_LOW(num_low), .MAIN_COUNT(main_c), .PLUS_FOUR(p4), .PLUS_ONE(p1),
    .PRESCALER_SEL(psel_o), .PRESCALER_BASE(base), .SPARE_BIT_FREE(free), .DIVIDE_TOTAL(total),
    .POWERDOWN(pd_o), .REF_DIV(ref_o), .DEN_LOW(den_o), .LOCK_REINIT(reinit));
  rfnd_host #(.SCK_HALF(2)) rfnd_host_inst (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitreq), .link(link));
  rfnd_link_asserts #(.SCK_HALF(2)) rfnd_link_asserts_inst (.MCLK(MCLK), .RST_N(RST_N),
    .ser_clk(link.ser_clk), .ser_data(link.ser_data), .latch_strobe(link.latch_strobe));

  initial
  begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one bus cycle, entered just after a rising edge
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wdat <= d;
    rd <= r;
    wr <= !r;
    // request stands until an edge samples waitrequest low
    @(posedge MCLK);
    while (waitreq !== 1'b0)
    begin
      k++;
      if (k > 500)
      begin
        n_errors++;
        print_verdict();
      end
      @(posedge MCLK);
    end
    rdat = readdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge before the next request
    @(posedge MCLK);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    bus(1'b1, OFS_STATUS, 32'h0);
    while (rdat[STS_BUSY] !== 1'b0)
    begin
      k++;
      if (k > 200)
      begin
        n_errors++;
        print_verdict();
      end
      bus(1'b1, OFS_STATUS, 32'h0);
    end
  endtask

  function automatic bit legal(input logic ps, input logic [2:0] o, input logic [10:0] n);
    bit o2;
    bit o3;
    o2 = (o == ORD_SECOND);
    o3 = o2 || (o == ORD_THIRD);
    if (!ps)
      return n >= SM_MIN && n <= SM_MAX && (n > SM_ORD3_MAX || o2 || (o3 && n > SM_ORD2_MAX));
    return n >= LG_MIN && n <= LG_MAX && ((n > LG_ORD3_LO && n < LG_ORD3_HI) || o2
      || (o3 && n > LG_ORD2_LO && n < LG_ORD2_HI));
  endfunction

  function automatic logic [11:0] total_of(input logic ps, input logic [10:0] n, input logic sp);
    logic [1:0] b;
    b = ps ? n[3:2] : {sp, n[2]};
    return (ps ? 12'h010 : 12'h008) * n[10:4] + {8'h00, b, 2'h0} + {10'h000, n[1:0]};
  endfunction

  // link monitor: rebuilds each word and counts restart pulses
  always @(posedge MCLK)
  begin
    clk_d <= link.ser_clk;
    stb_d <= link.latch_strobe;
    if (reinit === 1'b1)
      reinits++;
    if (link.ser_clk && !clk_d)
      mon_sr <= {mon_sr[22:0], link.ser_data};
    if (link.latch_strobe && !stb_d)
      chk("link_word", mon_sr, exp_word);
  end

  initial
  begin
    logic [10:0] sm [8];
    logic [10:0] lg [8];
    logic [10:0] n;
    logic [10:0] mn;
    logic [11:0] num;
    logic [11:0] mnum;
    logic [31:0] cfg;
    bit          ok;
    int          exp_re;
    sm = '{11'h018, 11'h019, 11'h01A, 11'h01B, 11'h01E, 11'h01F, 11'h3FF, 11'h400};
    lg = '{11'h030, 11'h031, 11'h033, 11'h036, 11'h7F7, 11'h7FB, 11'h7FD, 11'h7FE};
    {RST_N, spare, rd, wr, clk_d, stb_d} = 6'h00;
    {adr, wdat, mon_sr, exp_word} = '0;
    {n_errors, checks, reinits, exp_re} = '0;
    {mn, mnum} = '0;
    void'($urandom(5));
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    chk("base_rst", base, 32'h8);
    chk("free_rst", free, 32'h1);
    bus(1'b1, OFS_ORDER, 32'h0);
    chk("order_rst", rdat, 32'h3);
    bus(1'b0, 4'h6, 32'hFFFF_FFFF);
    bus(1'b1, 4'h6, 32'h0);
    chk("unmapped", rdat, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      cfg = $urandom;
      cfg[PSEL_BIT] = p[0];
      exp_word = {cfg[23:4], ADDR_R1};
      bus(1'b0, OFS_CONFIG, {8'h00, cfg[23:0]});
      wait_idle();
      chk("pd", pd_o, cfg[PD_BIT]);
      chk("psel", psel_o, cfg[PSEL_BIT]);
      chk("ref", ref_o, cfg[RDIV_MSB:RDIV_LSB]);
      chk("den", den_o, cfg[DEN_MSB:DEN_LSB]);
      chk("base", base, p ? 32'h10 : 32'h8);
      chk("free", free, !p);
      chk("reinit_cfg", reinits, exp_re);
      for (int o = 2; o < 5; o++)
      begin
        bus(1'b0, OFS_ORDER, o);
        for (int i = 0; i < 8; i++)
        begin
          n = p ? lg[i] : sm[i];
          num = $urandom;
          spare <= $urandom;
          ok = legal(p[0], o[2:0], n);
          exp_word = {n, num, N_SEL_VAL};
          bus(1'b0, OFS_DIVIDE, {4'h0, num, 5'h00, n});
          wait_idle();
          if (ok)
          begin
            mn = n;
            mnum = num;
            exp_re++;
          end
          chk("n_word", n_word, mn);
          chk("num_low", num_low, mnum);
          chk("main_c", main_c, mn[10:4]);
          chk("plus_four", p4, mn[3:2]);
          chk("plus_one", p1, mn[1:0]);
          chk("total", total, total_of(p[0], mn, spare));
          chk("refused", rdat[STS_REFUSE], !ok);
          chk("reinit", reinits, exp_re);
          if (!ok)
            bus(1'b0, OFS_STATUS, 32'h2);
        end
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
